// ### core/dram_ctrl_pkg.sv
// package: timing constants, states and carriers for the strobe controller
`default_nettype none
package dram_ctrl_pkg;

    localparam int CLK_PERIOD_NS = 40;
    // minimum times in ns (fastest grade), except the refresh interval, which is a maximum
    localparam int ROW_HOLD_NS = 20;
    localparam int ROW_TO_COL_NS = 25;
    localparam int ROW_ACCESS_NS = 120;
    localparam int COL_ACCESS_NS = 60;
    localparam int RAS_WIDTH_NS = 120;
    localparam int RAS_PRECHARGE_NS = 100;
    localparam int RANDOM_CYCLE_NS = 230;
    localparam int RW_CYCLE_NS = 255;
    localparam int COL_TO_WRITE_NS = 40;
    localparam int ROW_TO_WRITE_NS = 100;
    localparam int WRITE_PULSE_NS = 40;
    localparam int WRITE_HOLD_ROW_NS = 100;
    localparam int COL_ADDR_HOLD_ROW_NS = 80;
    localparam int OFF_DELAY_NS = 35;
    localparam int POWERUP_NS = 100000;
    localparam int REFRESH_INTERVAL_NS = 2000000;
    localparam int INIT_RAS_CYCLES = 8;
    localparam int REFRESH_ROWS = 128;

    // cycle counts: minimums round up
    localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_ACCESS_CYC = (ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_ACCESS_CYC = (COL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_WIDTH_CYC = (RAS_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_PRECHARGE_CYC = (RAS_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RANDOM_CYCLE_CYC = (RANDOM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RW_CYCLE_CYC = (RW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_TO_WRITE_CYC = (COL_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_DELAY_CYC = (OFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest interval rounds down
    localparam int REFRESH_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS / REFRESH_ROWS;

    localparam int ADDR_W = 16;
    localparam int MUX_W = 8;
    localparam int CNT_W = 16;
    localparam int RAS_MIN_TOTAL =
        (RAS_WIDTH_CYC + RAS_PRECHARGE_CYC > RANDOM_CYCLE_CYC) ?
        RAS_WIDTH_CYC + RAS_PRECHARGE_CYC : RANDOM_CYCLE_CYC;

    typedef enum logic [8:0] {
        ST_POWERUP = 9'h001,
        ST_INIT = 9'h002,
        ST_IDLE = 9'h004,
        ST_ROW = 9'h008,
        ST_COL = 9'h010,
        ST_ACCESS = 9'h020,
        ST_RMW_WE = 9'h040,
        ST_REFRESH = 9'h080,
        ST_PRECHARGE = 9'h100
    } ctrl_state_e;

    // user request carrier
    typedef struct packed {
        logic valid;
        logic write;
        logic rmw;
        logic [ADDR_W-1:0] addr;
        logic wdata;
    } mem_req_s;

    // memory pins driven by the controller
    typedef struct packed {
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_select_n;
        logic [MUX_W-1:0] mux_address_lines;
        logic data_in;
    } mem_pins_s;

endpackage
`default_nettype wire

// ### core/dram_strobe_ctrl.sv
// module: strobe-sequencing controller for a 64k x 1 multiplexed dram
`timescale 1ns/1ps
`default_nettype none

module dram_strobe_ctrl #(
    parameter int POWERUP_CYCLES = dram_ctrl_pkg::POWERUP_CYC,
    parameter int REFRESH_CYCLES = dram_ctrl_pkg::REFRESH_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire dram_ctrl_pkg::mem_req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_data,
    output logic init_done,
    output dram_ctrl_pkg::mem_pins_s pins,
    input wire logic data_out
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        dram_ctrl_pkg::ctrl_state_e state;
        logic [dram_ctrl_pkg::CNT_W-1:0] phase;
        logic [dram_ctrl_pkg::CNT_W-1:0] wait_cnt;
        logic [dram_ctrl_pkg::CNT_W-1:0] refresh_cnt;
        logic refresh_due;
        logic [3:0] init_cnt;
        logic [6:0] refresh_row;
        logic [dram_ctrl_pkg::ADDR_W-1:0] addr;
        logic write;
        logic rmw;
        logic wdata;
        logic ready;
        logic rsp_valid;
        logic rsp_data;
        logic init_done;
        dram_ctrl_pkg::mem_pins_s pins;
        logic [2:0] dq_sync;
    } ctrl_s;

    localparam logic [dram_ctrl_pkg::CNT_W-1:0] ONE = 16'h0001;

    ctrl_s st_reg;
    ctrl_s st_next;

    // ************************************************************
    // sequencing
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;
        st_next.ready = 1'b0;
        st_next.phase = st_reg.phase + ONE;
        st_next.dq_sync = {st_reg.dq_sync[1:0], data_out};
        case (st_reg.state)
            dram_ctrl_pkg::ST_POWERUP: begin
                st_next.wait_cnt = st_reg.wait_cnt + ONE;
                if (st_reg.wait_cnt >= POWERUP_CYCLES[dram_ctrl_pkg::CNT_W-1:0]) begin
                    st_next.state = dram_ctrl_pkg::ST_INIT;
                    st_next.phase = '0;
                end
            end
            dram_ctrl_pkg::ST_INIT: begin
                // row-only warm-up cycles, column strobe held high
                st_next.pins.mux_address_lines = {1'b0, st_reg.refresh_row};
                st_next.pins.row_strobe_n =
                    !(st_reg.phase >= ONE && st_reg.phase < ONE + 16'(dram_ctrl_pkg::RAS_WIDTH_CYC));
                if (st_reg.phase >= 16'(dram_ctrl_pkg::RAS_MIN_TOTAL)) begin
                    st_next.phase = '0;
                    st_next.refresh_row = st_reg.refresh_row + 7'h01;
                    st_next.init_cnt = st_reg.init_cnt + 4'h1;
                    if (st_reg.init_cnt == 4'(dram_ctrl_pkg::INIT_RAS_CYCLES - 1)) begin
                        st_next.state = dram_ctrl_pkg::ST_IDLE;
                        st_next.init_done = 1'b1;
                        st_next.ready = 1'b1;
                    end
                end
            end
            dram_ctrl_pkg::ST_IDLE: begin
                st_next.ready = !st_reg.refresh_due && !(st_reg.ready && req.valid);
                st_next.phase = '0;
                // a request seen with ready high is taken; a due refresh waits for its precharge
                if (st_reg.ready && req.valid) begin
                    st_next.state = dram_ctrl_pkg::ST_ROW;
                    st_next.addr = req.addr;
                    st_next.write = req.write;
                    st_next.rmw = req.rmw;
                    st_next.wdata = req.wdata;
                    // row half set up a clock ahead of the strobe
                    st_next.pins.mux_address_lines = req.addr[15:8];
                    // early write: select low ahead of the column strobe
                    st_next.pins.write_select_n = !(req.write && !req.rmw);
                    st_next.pins.data_in = req.wdata;
                end else if (st_reg.refresh_due) begin
                    st_next.state = dram_ctrl_pkg::ST_REFRESH;
                    st_next.refresh_due = 1'b0;
                    st_next.ready = 1'b0;
                    st_next.pins.mux_address_lines = {1'b0, st_reg.refresh_row};
                end
            end
            dram_ctrl_pkg::ST_ROW: begin
                st_next.pins.row_strobe_n = 1'b0;
                st_next.state = dram_ctrl_pkg::ST_COL;
                st_next.phase = '0;
            end
            dram_ctrl_pkg::ST_COL: begin
                // after row hold, swap to column half then drop column strobe
                if (st_reg.phase == 16'(dram_ctrl_pkg::ROW_HOLD_CYC - 1)) begin
                    st_next.pins.mux_address_lines = st_reg.addr[7:0];
                end
                if (st_reg.phase == 16'(dram_ctrl_pkg::ROW_HOLD_CYC)) begin
                    st_next.pins.col_strobe_n = 1'b0;
                    st_next.state = dram_ctrl_pkg::ST_ACCESS;
                    st_next.phase = '0;
                end
            end
            dram_ctrl_pkg::ST_ACCESS: begin
                // hold strobes for row width and access time, plus sync delay
                if (st_reg.rmw && st_reg.phase == 16'(dram_ctrl_pkg::ROW_ACCESS_CYC)) begin
                    st_next.state = dram_ctrl_pkg::ST_RMW_WE;
                    st_next.phase = '0;
                end else if (!st_reg.rmw &&
                             st_reg.phase == 16'(dram_ctrl_pkg::ROW_ACCESS_CYC + 3)) begin
                    st_next.pins.row_strobe_n = 1'b1;
                    st_next.pins.col_strobe_n = 1'b1;
                    st_next.pins.write_select_n = 1'b1;
                    st_next.rsp_data = st_reg.dq_sync[2];
                    st_next.rsp_valid = 1'b1;
                    st_next.state = dram_ctrl_pkg::ST_PRECHARGE;
                    st_next.phase = '0;
                end
            end
            dram_ctrl_pkg::ST_RMW_WE: begin
                // late write select strobes the data, then the synchronised read is captured a cycle later
                if (st_reg.phase == 16'(dram_ctrl_pkg::ROW_ACCESS_CYC - 1)) begin
                    st_next.rsp_data = st_reg.dq_sync[2];
                end
                if (st_reg.phase == 16'(dram_ctrl_pkg::COL_TO_WRITE_CYC)) begin
                    st_next.pins.write_select_n = 1'b0;
                end
                if (st_reg.phase == 16'(dram_ctrl_pkg::COL_TO_WRITE_CYC
                                        + dram_ctrl_pkg::WRITE_PULSE_CYC + 1)) begin
                    st_next.pins.row_strobe_n = 1'b1;
                    st_next.pins.col_strobe_n = 1'b1;
                    st_next.pins.write_select_n = 1'b1;
                    st_next.rsp_valid = 1'b1;
                    st_next.state = dram_ctrl_pkg::ST_PRECHARGE;
                    st_next.phase = '0;
                end
            end
            dram_ctrl_pkg::ST_REFRESH: begin
                st_next.pins.row_strobe_n =
                    !(st_reg.phase < 16'(dram_ctrl_pkg::RAS_WIDTH_CYC));
                if (st_reg.phase == 16'(dram_ctrl_pkg::RAS_WIDTH_CYC)) begin
                    st_next.refresh_row = st_reg.refresh_row + 7'h01;
                    st_next.state = dram_ctrl_pkg::ST_PRECHARGE;
                    st_next.phase = '0;
                end
            end
            dram_ctrl_pkg::ST_PRECHARGE: begin
                // precharge long enough for random or read-write cycle spacing
                if (st_reg.phase >= 16'(dram_ctrl_pkg::RW_CYCLE_CYC
                                        - dram_ctrl_pkg::RAS_WIDTH_CYC)) begin
                    st_next.state = dram_ctrl_pkg::ST_IDLE;
                    st_next.ready = !st_reg.refresh_due;
                end
            end
            default: begin
                st_next.state = dram_ctrl_pkg::ST_POWERUP;
            end
        endcase
        // refresh timer after the states, so a new tick wins over a same-cycle clear
        if (st_reg.init_done && st_reg.refresh_cnt >= REFRESH_CYCLES[dram_ctrl_pkg::CNT_W-1:0] - ONE) begin
            st_next.refresh_cnt = '0;
            st_next.refresh_due = 1'b1;
        end else begin
            st_next.refresh_cnt = st_reg.refresh_cnt + ONE;
        end
    end

    // ************************************************************
    // register
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.state <= dram_ctrl_pkg::ST_POWERUP;
            st_reg.pins.row_strobe_n <= 1'b1;
            st_reg.pins.col_strobe_n <= 1'b1;
            st_reg.pins.write_select_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign req_ready = st_reg.ready;
    assign rsp_valid = st_reg.rsp_valid;
    assign rsp_data = st_reg.rsp_data;
    assign init_done = st_reg.init_done;
    assign pins = st_reg.pins;

endmodule

`default_nettype wire

// ### verification/dram_strobe_ctrl_props.sv
// checker: strobe order and timing at the dram controller pins
`timescale 1ns/1ps
`default_nettype none
// ****************
// timing checker
// ****************
module dram_strobe_ctrl_props #(
    parameter int POWERUP_CYCLES = dram_ctrl_pkg::POWERUP_CYC,
    parameter int REFRESH_CYCLES = dram_ctrl_pkg::REFRESH_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire dram_ctrl_pkg::mem_req_s req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_data,
    input wire logic init_done,
    input wire dram_ctrl_pkg::mem_pins_s pins,
    input wire logic data_out
);
    logic [15:0] cyc_reg;
    logic [3:0] rows_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // cycles since reset and row strobe falls, both saturating
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cyc_reg <= 16'h0000;
            rows_reg <= 4'h0;
        end else begin
            cyc_reg <= (cyc_reg == 16'hFFFF) ? cyc_reg : cyc_reg + 16'h0001;
            if ($fell(pins.row_strobe_n) && rows_reg != 4'hF) rows_reg <= rows_reg + 4'h1;
        end
    end
    sequence s_we_held;
        (!pins.write_select_n)[*3];
    endsequence
    sequence s_no_row_fall;
        (!$fell(pins.row_strobe_n))[*5];
    endsequence
    a_row_addr_stable: assert property ($fell(pins.row_strobe_n) |->
        $stable(pins.mux_address_lines))
        else $error("row address moved at row strobe");
    a_col_gated: assert property ($fell(pins.col_strobe_n) |-> !pins.row_strobe_n &&
        $past(pins.row_strobe_n) == 1'b0 && $stable(pins.mux_address_lines))
        else $error("column strobe without settled row");
    a_col_addr_hold: assert property ($fell(pins.col_strobe_n) |=>
        $stable(pins.mux_address_lines))
        else $error("column address not held");
    a_we_held_row: assert property ($fell(pins.row_strobe_n) && !pins.write_select_n
        |-> s_we_held)
        else $error("write select released early");
    a_we_fall_timing: assert property ($fell(pins.write_select_n) |->
        pins.col_strobe_n || ($past(pins.col_strobe_n) == 1'b0 &&
        $past(pins.row_strobe_n, 3) == 1'b0))
        else $error("write select fell in the undefined window");
    a_row_cycle_gap: assert property ($fell(pins.row_strobe_n) |=> s_no_row_fall)
        else $error("row cycles too close");
    a_init_rows: assert property ($rose(init_done) |-> rows_reg >= 4'h8)
        else $error("init done before eight row cycles");
    a_powerup_wait: assert property ($fell(pins.row_strobe_n) |->
        cyc_reg >= 16'(POWERUP_CYCLES - 1))
        else $error("row strobe before power-up wait");
endmodule
bind dram_strobe_ctrl dram_strobe_ctrl_props #(.POWERUP_CYCLES(POWERUP_CYCLES),
    .REFRESH_CYCLES(REFRESH_CYCLES)) props_u (.clock(clock), .rst_n(rst_n), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .init_done(init_done), .pins(pins), .data_out(data_out));
`default_nettype wire

// ### verification/dram_cell_model.sv
// partner: behavioural 64k x 1 multiplexed dram
`timescale 1ns/1ps
`default_nettype none
module dram_cell_model (
    input wire dram_ctrl_pkg::mem_pins_s pins,
    output logic data_out
);
    logic cells [0:65535];
    logic [7:0] row_q;
    logic [7:0] col_q;
    logic out_ok = 1'b0;
    logic out_bit = 1'b0;
    time row_t = 0;
    // row half latched on the row strobe fall
    always @(negedge pins.row_strobe_n) begin
        row_q = pins.mux_address_lines;
        row_t = $time;
    end
    // column latch, early write, read data after access time
    always @(negedge pins.col_strobe_n) begin
        col_q = pins.mux_address_lines;
        out_bit = cells[{row_q, col_q}];
        if (!pins.row_strobe_n && !pins.write_select_n) cells[{row_q, col_q}] = pins.data_in;
        else if (!pins.row_strobe_n) begin
            #(dram_ctrl_pkg::COL_ACCESS_NS);
            while ($time < row_t + dram_ctrl_pkg::ROW_ACCESS_NS) #1;
            if (!pins.col_strobe_n) out_ok = 1'b1;
        end
    end
    // late write select strobes data in a read-write cycle
    always @(negedge pins.write_select_n) begin
        if (!pins.col_strobe_n && !pins.row_strobe_n) cells[{row_q, col_q}] = pins.data_in;
    end
    always @(posedge pins.col_strobe_n) out_ok = 1'b0;
    // released output shows the inverse, so a bit sampled too early never looks valid
    assign data_out = out_ok ? out_bit : ~out_bit;
endmodule
`default_nettype wire

// ### verification/dram_strobe_ctrl_tb.sv
// testbench: dram strobe controller against the cell model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dram_strobe_ctrl_tb;
    localparam int PWR = 4;
    localparam int REF = 50;
    logic clock = 1'b0;
    logic rst_n, req_ready, rsp_valid, rsp_data, init_done, data_out, got, watch;
    dram_ctrl_pkg::mem_req_s req;
    dram_ctrl_pkg::mem_pins_s pins;
    logic [127:0] seen;
    int fails, n_tests, rf;
    always #20 clock = ~clock;
    dram_strobe_ctrl #(.POWERUP_CYCLES(PWR), .REFRESH_CYCLES(REF)) dut_u (.clock(clock),
        .rst_n(rst_n), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .init_done(init_done), .pins(pins), .data_out(data_out));
    dram_cell_model mem_u (.pins(pins), .data_out(data_out));
    // count row strobes and note refreshed rows while idle
    always @(negedge pins.row_strobe_n) begin
        rf++;
        if (watch) seen[pins.mux_address_lines[6:0]] = 1'b1;
    end
    // ****************
    // bus and reporting tasks
    // ****************
    task automatic access(input logic wr, input logic rm, input logic [15:0] a,
        input logic d);
        @(posedge clock);
        req <= '{valid: 1'b1, write: wr, rmw: rm, addr: a, wdata: d};
        for (int k = 0; k < 100; k++) begin
            @(negedge clock);
            if (req_ready === 1'b1) break;
        end
        @(posedge clock);
        req <= '0;
        @(negedge clock);
        `CHK(req_ready, 1'b0)
        for (int k = 0; k < 100; k++) begin
            @(negedge clock);
            if (rsp_valid === 1'b1) break;
        end
        `CHK(rsp_valid, 1'b1)
        got = rsp_data;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_init();
        for (int k = 0; k < 300; k++) begin
            @(negedge clock);
            if (init_done === 1'b1) break;
        end
        `CHK(init_done, 1'b1)
        `CHK(rf >= 8, 1'b1)
        $display("init test done");
    endtask
    task automatic t_data();
        logic [15:0] a [4] = '{16'h0001, 16'h0100, 16'hFFFF, 16'h0000};
        logic [3:0] d = 4'h9;
        for (int k = 0; k < 4; k++) access(1'b1, 1'b0, a[k], d[k]);
        for (int k = 0; k < 4; k++) begin
            access(1'b0, 1'b0, a[k], ~d[k]);
            `CHK(got, d[k])
        end
        $display("write read test done");
    endtask
    task automatic t_rmw();
        access(1'b0, 1'b1, 16'hFFFF, 1'b1);
        `CHK(got, 1'b0)
        access(1'b0, 1'b0, 16'hFFFF, 1'b0);
        `CHK(got, 1'b1)
        $display("read modify write test done");
    endtask
    task automatic t_refresh();
        seen = '0;
        watch = 1'b1;
        repeat (130 * REF) @(posedge clock);
        watch = 1'b0;
        `CHK(&seen, 1'b1)
        $display("refresh test done");
    endtask
    initial begin
        req = '0;
        rst_n = 1'b0;
        watch = 1'b0;
        seen = '0;
        fails = 0;
        n_tests = 0;
        rf = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_init();
        t_data();
        t_rmw();
        t_refresh();
        results();
    end
    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        results();
    end
endmodule
`default_nettype wire
